/* File: encoder_obj_consts.svh */
`ifndef ENCODER_OBJ_CONSTS_SVH
`define ENCODER_OBJ_CONSTS_SVH

// object indices
`define IDX_OPERATING_PARAM 16'h6000
`define IDX_CYCLIC_TX_PERIOD 16'h6200
`define IDX_OPERATING_STATUS 16'h6500
`define IDX_MAX_TURN_RES 16'h6501
`define IDX_MAX_TOTAL_RANGE 16'h6502
`define IDX_ALARM_FLAGS 16'h6503
`define IDX_ALARM_SUPPORT 16'h6504
`define IDX_WARNING_FLAGS 16'h6505
`define IDX_WARNING_SUPPORT 16'h6506
`define IDX_VERSION 16'h6507
`define IDX_OPERATING_TIME 16'h6508

// reset values and constant contents
`define RST_CYCLIC_TX_PERIOD 16'h0302
`define RST_OPERATING_PARAM 16'h0004
`define ALARM_SUPPORT_MASK 16'h0001
`define WARN_SUPPORT_MULTI 16'h0014
`define WARN_SUPPORT_SINGLE 16'h0004
`define RES_FINE 32'h0004_0000
`define RES_COARSE 32'h0000_2000
`define RANGE_FINE_MULTI 32'h0000_0000
`define RANGE_COARSE_MULTI 32'h2000_0000

// field positions
`define BIT_DIRECTION 0
`define BIT_SCALING 2
`define BIT_POS_ERROR 0
`define BIT_WATCHDOG 2
`define BIT_BATTERY 4

// timing
`define REF_CLK_HZ 25000000
`define MS_TICK_TIME_US 1000
`define MS_TICK_CYCLES (`REF_CLK_HZ / 1000000 * `MS_TICK_TIME_US)
`define TENTH_HOUR_TIME_MIN 6
`define TENTH_HOUR_MS (`TENTH_HOUR_TIME_MIN * 60 * 1000)

`endif

/* File: encoder_obj_pkg.sv */
package encoder_obj_pkg;

    // device variant: resolution class and turn range
    typedef enum {
        FINE_MULTI,
        FINE_SINGLE,
        COARSE_MULTI,
        COARSE_SINGLE
    } variant_t;

    // one object access from the protocol engine
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [31:0] wdata;
    } obj_req_t;

    // answer, one cycle after the access
    typedef struct packed {
        logic ack;
        logic abort;
        logic [31:0] rdata;
    } obj_resp_t;

endpackage

/* File: encoder_profile_object_bank.sv */
// Behaviour
// - period zero: no periodic transmission of the first process data object
// - nonzero period n: transmit first process data object every n milliseconds
// - period object is read-write, resets to 302h, acts as event timer
// - operating status is read-only mirror of last operating parameter, default 4h
// - status bit 0: zero clockwise, one counterclockwise counting
// - status bit 2: zero native resolution, one saved resolution
// - max singleturn resolution is read-only 8192 or 262144 per variant
// - max overall range is read-only per-variant 32-bit constant
// - alarm word bit 0 set while position error active, else zero
// - supported alarms word is read-only constant 1h
// - warning bit 2 set after a processor watchdog reset
// - multiturn only: warning bit 4 set when battery charge low
// - supported warnings is 14h multiturn, 04h singleturn
// - version word: profile low, high in bytes 0,1; firmware in 2,3
// - operating time counts tenths of an hour from zero after reset
`timescale 1ns/1ps
`include "encoder_obj_consts.svh"

module encoder_profile_object_bank #(
    parameter encoder_obj_pkg::variant_t variant = encoder_obj_pkg::FINE_MULTI,
    parameter int ms_cycles = `MS_TICK_CYCLES,
    parameter int tenth_hour_ms = `TENTH_HOUR_MS,
    // arbitrary version values, not tied to any product
    parameter logic [15:0] profile_version = 16'h0001,
    parameter logic [15:0] firmware_version = 16'h0001
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // object access from the protocol engine
    input wire encoder_obj_pkg::obj_req_t obj_req,
    output encoder_obj_pkg::obj_resp_t obj_resp,
    // sensor status
    input wire logic position_error,
    input wire logic watchdog_reset_seen,
    input wire logic battery_low,
    // process data and operating mode
    output logic pdo1_tx_req,
    output logic direction_ccw,
    output logic scaling_saved
);

    // variant-dependent constants
    localparam bit fine_res = (variant == encoder_obj_pkg::FINE_MULTI) ||
                              (variant == encoder_obj_pkg::FINE_SINGLE);
    localparam bit multiturn = (variant == encoder_obj_pkg::FINE_MULTI) ||
                               (variant == encoder_obj_pkg::COARSE_MULTI);
    localparam logic [31:0] max_res = fine_res ? `RES_FINE : `RES_COARSE;
    // 2^32 does not fit the word; the fine multiturn range reads as zero
    localparam logic [31:0] max_range = multiturn ?
        (fine_res ? `RANGE_FINE_MULTI : `RANGE_COARSE_MULTI) : max_res;
    localparam logic [15:0] warn_support = multiturn ?
        `WARN_SUPPORT_MULTI : `WARN_SUPPORT_SINGLE;
    localparam logic [31:0] ms_last = 32'(ms_cycles - 1);
    localparam logic [31:0] tenth_last = 32'(tenth_hour_ms - 1);

    logic [31:0] ms_div;
    logic ms_tick;
    logic [31:0] tenth_div;
    logic tenth_wrap;
    logic [31:0] op_time;
    logic [15:0] tx_period;
    logic [15:0] period_count;
    logic [15:0] op_param;
    logic watchdog_flag;
    logic [15:0] alarm_word;
    logic [15:0] warning_word;
    logic known_index;
    logic writable_index;
    logic wr_period;
    logic wr_param;
    logic [31:0] read_value;

    // millisecond divider from the reference clock
    always_ff @(posedge ref_clk) begin
        if (!rstn || ms_div == ms_last) begin
            ms_div <= 32'h0000_0000;
        end else begin
            ms_div <= ms_div + 32'h0000_0001;
        end
    end

    assign ms_tick = (ms_div == ms_last);

    // tenth-of-hour divider counting milliseconds
    assign tenth_wrap = ms_tick && (tenth_div == tenth_last);

    always_ff @(posedge ref_clk) begin
        if (!rstn || tenth_wrap) begin
            tenth_div <= 32'h0000_0000;
        end else if (ms_tick) begin
            tenth_div <= tenth_div + 32'h0000_0001;
        end
    end

    // operating time restarts at every reset, wraps silently at the top
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            op_time <= 32'h0000_0000;
        end else if (tenth_wrap) begin
            op_time <= op_time + 32'h0000_0001;
        end
    end

    // access decode
    always_comb begin
        known_index = 1'b1;
        writable_index = 1'b0;
        case (obj_req.index)
            `IDX_OPERATING_PARAM: writable_index = 1'b1;
            `IDX_CYCLIC_TX_PERIOD: writable_index = 1'b1;
            `IDX_OPERATING_STATUS, `IDX_MAX_TURN_RES, `IDX_MAX_TOTAL_RANGE,
            `IDX_ALARM_FLAGS, `IDX_ALARM_SUPPORT, `IDX_WARNING_FLAGS,
            `IDX_WARNING_SUPPORT, `IDX_VERSION, `IDX_OPERATING_TIME: known_index = 1'b1;
            default: known_index = 1'b0;
        endcase
    end

    assign wr_period = obj_req.valid && obj_req.write &&
                       (obj_req.index == `IDX_CYCLIC_TX_PERIOD);
    assign wr_param = obj_req.valid && obj_req.write &&
                      (obj_req.index == `IDX_OPERATING_PARAM);

    // cyclic period, nonvolatile restore is done by the engine writing it back
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tx_period <= `RST_CYCLIC_TX_PERIOD;
        end else if (wr_period) begin
            tx_period <= obj_req.wdata[15:0];
        end
    end

    // operating parameter, mirrored read-only at the status index
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            op_param <= `RST_OPERATING_PARAM;
        end else if (wr_param) begin
            op_param <= obj_req.wdata[15:0];
        end
    end

    assign direction_ccw = op_param[`BIT_DIRECTION];
    assign scaling_saved = op_param[`BIT_SCALING];

    // period counter; a new period restarts the phase so no stale interval fires
    always_ff @(posedge ref_clk) begin
        if (!rstn || wr_period || tx_period == 16'h0000) begin
            period_count <= 16'h0000;
        end else if (ms_tick) begin
            if (period_count == tx_period - 16'h0001) begin
                period_count <= 16'h0000;
            end else begin
                period_count <= period_count + 16'h0001;
            end
        end
    end

    // transmit request, one cycle per elapsed period
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pdo1_tx_req <= 1'b0;
        end else begin
            pdo1_tx_req <= ms_tick && !wr_period && (tx_period != 16'h0000) &&
                           (period_count == tx_period - 16'h0001);
        end
    end

    // watchdog warning is sticky; only a device reset clears it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            watchdog_flag <= 1'b0;
        end else if (watchdog_reset_seen) begin
            watchdog_flag <= 1'b1;
        end
    end

    // live alarm and warning words
    always_comb begin
        alarm_word = 16'h0000;
        alarm_word[`BIT_POS_ERROR] = position_error;
        warning_word = 16'h0000;
        warning_word[`BIT_WATCHDOG] = watchdog_flag;
        warning_word[`BIT_BATTERY] = multiturn && battery_low;
    end

    // read multiplexer
    always_comb begin
        case (obj_req.index)
            `IDX_OPERATING_PARAM: read_value = {16'h0000, op_param};
            `IDX_CYCLIC_TX_PERIOD: read_value = {16'h0000, tx_period};
            `IDX_OPERATING_STATUS: read_value = {16'h0000, op_param};
            `IDX_MAX_TURN_RES: read_value = max_res;
            `IDX_MAX_TOTAL_RANGE: read_value = max_range;
            `IDX_ALARM_FLAGS: read_value = {16'h0000, alarm_word};
            `IDX_ALARM_SUPPORT: read_value = {16'h0000, `ALARM_SUPPORT_MASK};
            `IDX_WARNING_FLAGS: read_value = {16'h0000, warning_word};
            `IDX_WARNING_SUPPORT: read_value = {16'h0000, warn_support};
            `IDX_VERSION: read_value = {firmware_version, profile_version};
            `IDX_OPERATING_TIME: read_value = op_time;
            default: read_value = 32'h0000_0000;
        endcase
    end

    // registered answer; write to read-only or unknown index aborts with no effect
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            obj_resp <= '0;
        end else begin
            obj_resp.ack <= obj_req.valid;
            obj_resp.abort <= obj_req.valid &&
                              (!known_index || (obj_req.write && !writable_index));
            obj_resp.rdata <= (obj_req.valid && !obj_req.write) ?
                              read_value : 32'h0000_0000;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // helper: milliseconds since last transmission or period change
    logic [16:0] gap_ticks;

    always_ff @(posedge ref_clk) begin
        if (!rstn || pdo1_tx_req || wr_period) begin
            gap_ticks <= 17'h0_0000;
        end else if (ms_tick) begin
            gap_ticks <= gap_ticks + 17'h0_0001;
        end
    end

    pdo_off_a: assert property (
        tx_period == 16'h0000 |-> !pdo1_tx_req
    ) else $error("transmission while period is zero");

    pdo_period_a: assert property (
        pdo1_tx_req |-> gap_ticks == {1'b0, tx_period}
    ) else $error("transmission interval differs from period");

    period_reset_a: assert property (
        $past(!rstn) |-> tx_period == `RST_CYCLIC_TX_PERIOD
    ) else $error("period reset value wrong");

    period_write_a: assert property (
        wr_period |=> tx_period == $past(obj_req.wdata[15:0]) && obj_resp.ack && !obj_resp.abort
    ) else $error("period write not taken");

    param_write_a: assert property (
        wr_param |=> op_param == $past(obj_req.wdata[15:0]) && obj_resp.ack && !obj_resp.abort
    ) else $error("parameter write not taken");

    status_mirror_a: assert property (
        obj_req.valid && !obj_req.write && obj_req.index == `IDX_OPERATING_STATUS
        |=> obj_resp.rdata == {16'h0000, $past(op_param)} && !obj_resp.abort
    ) else $error("status does not mirror parameter");

    status_readonly_a: assert property (
        obj_req.valid && obj_req.write && obj_req.index == `IDX_OPERATING_STATUS
        |=> obj_resp.abort && $stable(op_param)
    ) else $error("status write not refused");

    mode_bits_a: assert property (
        wr_param |=> direction_ccw == $past(obj_req.wdata[0]) &&
        scaling_saved == $past(obj_req.wdata[2])
    ) else $error("mode outputs do not follow parameter");

    const_read_a: assert property (
        obj_req.valid && !obj_req.write && obj_req.index == `IDX_MAX_TURN_RES
        |=> obj_resp.rdata == max_res && !obj_resp.abort
    ) else $error("resolution read wrong");

    alarm_read_a: assert property (
        obj_req.valid && !obj_req.write && obj_req.index == `IDX_ALARM_FLAGS
        |=> obj_resp.rdata == {31'h0000_0000, $past(position_error)}
    ) else $error("alarm word wrong");

    watchdog_warn_a: assert property (
        watchdog_reset_seen |=> warning_word[`BIT_WATCHDOG] [*3]
    ) else $error("watchdog warning not held");

    optime_step_a: assert property (
        tenth_wrap |=> op_time == $past(op_time) + 32'h0000_0001
    ) else $error("operating time did not advance");

    optime_hold_a: assert property (
        !tenth_wrap |=> $stable(op_time)
    ) else $error("operating time moved without tick");

    ms_tick_a: assert property (
        ms_tick |=> !ms_tick
    ) else $error("millisecond tick too frequent");

    // singleturn parts have no battery, so the bit must stay low whatever the pin says
    battery_warn_a: assert property (
        obj_req.valid && !obj_req.write && obj_req.index == `IDX_WARNING_FLAGS
        |=> obj_resp.rdata[`BIT_BATTERY] == (multiturn && $past(battery_low))
    ) else $error("battery warning wrong for variant");

    warn_support_a: assert property (
        obj_req.valid && !obj_req.write && obj_req.index == `IDX_WARNING_SUPPORT
        |=> obj_resp.rdata == (multiturn ? {16'h0000, `WARN_SUPPORT_MULTI} :
        {16'h0000, `WARN_SUPPORT_SINGLE})
    ) else $error("supported warnings wrong");

    version_read_a: assert property (
        obj_req.valid && !obj_req.write && obj_req.index == `IDX_VERSION
        |=> obj_resp.rdata[7:0] == profile_version[7:0] &&
        obj_resp.rdata[15:8] == profile_version[15:8] &&
        obj_resp.rdata[31:16] == firmware_version
    ) else $error("version bytes out of place");

endmodule

/* File: encoder_profile_object_bank_bench.sv */
`timescale 1ns/1ps
`include "encoder_obj_consts.svh"

module encoder_profile_object_bank_bench;
    logic ref_clk, rstn, position_error, watchdog_reset_seen, battery_low;
    logic pdo1_tx_req, direction_ccw, scaling_saved, ab, ok;
    encoder_obj_pkg::obj_req_t obj_req;
    encoder_obj_pkg::obj_resp_t obj_resp;
    encoder_obj_pkg::obj_req_t obj_req_single;
    encoder_obj_pkg::obj_resp_t obj_resp_single;
    logic [31:0] rd, t0;
    logic [15:0] idx_tab [9];
    logic [31:0] exp_tab [9];
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    // distinct version halves so a swapped byte order shows up
    encoder_profile_object_bank #(
        .ms_cycles(4), .tenth_hour_ms(3),
        .profile_version(16'h2a1b), .firmware_version(16'h4c3d)
    ) i_encoder_profile_object_bank (
        .ref_clk(ref_clk), .rstn(rstn), .obj_req(obj_req), .obj_resp(obj_resp),
        .position_error(position_error), .watchdog_reset_seen(watchdog_reset_seen),
        .battery_low(battery_low), .pdo1_tx_req(pdo1_tx_req),
        .direction_ccw(direction_ccw), .scaling_saved(scaling_saved));

    object_master_model i_object_master_model (
        .ref_clk(ref_clk), .obj_req(obj_req), .obj_resp(obj_resp));

    // coarse singleturn variant on its own access path
    encoder_profile_object_bank #(
        .variant(encoder_obj_pkg::COARSE_SINGLE), .ms_cycles(4), .tenth_hour_ms(3)
    ) i_encoder_profile_object_bank_single (
        .ref_clk(ref_clk), .rstn(rstn), .obj_req(obj_req_single), .obj_resp(obj_resp_single),
        .position_error(position_error), .watchdog_reset_seen(watchdog_reset_seen),
        .battery_low(battery_low), .pdo1_tx_req(),
        .direction_ccw(), .scaling_saved());

    object_master_model i_object_master_model_single (
        .ref_clk(ref_clk), .obj_req(obj_req_single), .obj_resp(obj_resp_single));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // hang guard, generous against the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read and write with ack always expected, abort as given
    task automatic rd_obj(input logic [15:0] idx, input logic [31:0] exp, input logic exp_ab);
        i_object_master_model.access(0, 1'b0, idx, 32'h0, rd, ab, ok);
        check({31'h0, ok}, 32'h1);
        check({31'h0, ab}, {31'h0, exp_ab});
        check(rd, exp);
    endtask

    task automatic wr_obj(input logic [15:0] idx, input logic [31:0] wd, input logic exp_ab);
        i_object_master_model.access(0, 1'b1, idx, wd, rd, ab, ok);
        check({31'h0, ok}, 32'h1);
        check({31'h0, ab}, {31'h0, exp_ab});
    endtask

    // reads on the singleturn instance, never aborted
    task automatic rd_single(input logic [15:0] idx, input logic [31:0] exp);
        i_object_master_model_single.access(0, 1'b0, idx, 32'h0, rd, ab, ok);
        check({30'h0, ok, ab}, 32'h2);
        check(rd, exp);
    endtask

    // cycles from one transmit pulse to the next, 0 if none in 200 cycles
    task automatic pulse_gap(output int gap);
        int k;
        gap = 0;
        k = 0;
        while (pdo1_tx_req !== 1'b1 && k < 200) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        if (k < 200) begin
            do begin
                @(posedge ref_clk);
                #1;
                gap++;
            end while (pdo1_tx_req !== 1'b1 && gap < 200);
        end
    endtask

    initial begin
        rstn = 1'b0;
        position_error = 1'b0;
        watchdog_reset_seen = 1'b0;
        battery_low = 1'b0;
        idx_tab = '{`IDX_CYCLIC_TX_PERIOD, `IDX_OPERATING_STATUS, `IDX_MAX_TURN_RES,
            `IDX_MAX_TOTAL_RANGE, `IDX_ALARM_FLAGS, `IDX_ALARM_SUPPORT, `IDX_WARNING_FLAGS,
            `IDX_WARNING_SUPPORT, `IDX_VERSION};
        exp_tab = '{32'h302, 32'h4, 32'h4_0000, 32'h0, 32'h0, 32'h1, 32'h0, 32'h14, 32'h4c3d_2a1b};
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        check({30'h0, direction_ccw, scaling_saved}, 32'h1);

        // reset contents of every object except operating parameter and operating time
        for (int i = 0; i < 9; i++) begin
            rd_obj(idx_tab[i], exp_tab[i], 1'b0);
        end
        $display("test reset_values done");

        // read-only objects refuse writes, unknown index aborts
        for (int i = 1; i < 9; i++) begin
            wr_obj(idx_tab[i], 32'hffff, 1'b1);
            rd_obj(idx_tab[i], exp_tab[i], 1'b0);
        end
        rd_obj(16'h6600, 32'h0, 1'b1);
        $display("test read_only done");

        // operating parameter mirrored into status and mode outputs
        wr_obj(`IDX_OPERATING_PARAM, 32'h1, 1'b0);
        rd_obj(`IDX_OPERATING_STATUS, 32'h1, 1'b0);
        check({30'h0, direction_ccw, scaling_saved}, 32'h2);
        wr_obj(`IDX_OPERATING_PARAM, 32'h4, 1'b0);
        rd_obj(`IDX_OPERATING_STATUS, 32'h4, 1'b0);
        check({30'h0, direction_ccw, scaling_saved}, 32'h1);
        $display("test mirror done");

        // alarm live, watchdog sticky, battery live
        position_error <= 1'b1;
        rd_obj(`IDX_ALARM_FLAGS, 32'h1, 1'b0);
        position_error <= 1'b0;
        rd_obj(`IDX_ALARM_FLAGS, 32'h0, 1'b0);
        watchdog_reset_seen <= 1'b1;
        @(posedge ref_clk);
        watchdog_reset_seen <= 1'b0;
        battery_low <= 1'b1;
        rd_obj(`IDX_WARNING_FLAGS, 32'h14, 1'b0);
        rd_single(`IDX_WARNING_FLAGS, 32'h4);
        battery_low <= 1'b0;
        rd_obj(`IDX_WARNING_FLAGS, 32'h4, 1'b0);
        $display("test flags done");

        // coarse singleturn constants differ from the fine multiturn ones
        rd_single(`IDX_MAX_TURN_RES, 32'h2000);
        rd_single(`IDX_MAX_TOTAL_RANGE, 32'h2000);
        rd_single(`IDX_WARNING_SUPPORT, 32'h4);
        $display("test variant done");

        // cyclic transmission: off at zero, n ms apart otherwise
        wr_obj(`IDX_CYCLIC_TX_PERIOD, 32'h0, 1'b0);
        pulse_gap(n);
        check(n, 0);
        wr_obj(`IDX_CYCLIC_TX_PERIOD, 32'h2, 1'b0);
        rd_obj(`IDX_CYCLIC_TX_PERIOD, 32'h2, 1'b0);
        pulse_gap(n);
        check(n, 8);
        wr_obj(`IDX_CYCLIC_TX_PERIOD, 32'h5, 1'b0);
        pulse_gap(n);
        check(n, 20);
        $display("test cyclic done");

        // operating time: 120 cycles apart is exactly ten units of 3 ms at 4 cycles
        i_object_master_model.access(0, 1'b0, `IDX_OPERATING_TIME, 32'h0, t0, ab, ok);
        i_object_master_model.access(117, 1'b0, `IDX_OPERATING_TIME, 32'h0, rd, ab, ok);
        check(rd - t0, 32'ha);
        $display("test operating_time done");

        // a fresh reset restarts the time count and period
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        rd_obj(`IDX_OPERATING_TIME, 32'h0, 1'b0);
        rd_obj(`IDX_CYCLIC_TX_PERIOD, 32'h302, 1'b0);
        rd_obj(`IDX_WARNING_FLAGS, 32'h0, 1'b0);
        $display("test second_reset done");
        stop_test();
    end
endmodule

/* File: object_master_model.sv */
`timescale 1ns/1ps

module object_master_model (
    // clock
    input wire logic ref_clk,
    // object access towards the bank
    output encoder_obj_pkg::obj_req_t obj_req,
    input wire encoder_obj_pkg::obj_resp_t obj_resp
);
    initial begin
        obj_req = '0;
    end

    // one access after gap idle cycles; request stands one cycle, answer taken next edge
    task automatic access(input int gap, input logic wr, input logic [15:0] idx,
            input logic [31:0] wd, output logic [31:0] rd, output logic ab, output logic ok);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        obj_req <= '{valid: 1'b1, write: wr, index: idx, wdata: wd};
        @(posedge ref_clk);
        // released fields carry inverted junk so a stale request cannot look valid
        obj_req <= '{valid: 1'b0, write: ~wr, index: ~idx, wdata: ~wd};
        // the answer stands until the next edge and is taken there, before it updates
        @(posedge ref_clk);
        ok = obj_resp.ack;
        ab = obj_resp.abort;
        rd = obj_resp.rdata;
    endtask
endmodule
